// ### ddr_ctrl_end.sv
// Controller end: AXI4-Lite registers, reset and initialization sequencer, MRS and refresh issue.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module ddr_ctrl_end #(
    parameter int POST_RESET_CYC = ddr_init_pkg::POST_RESET_CYC,
    parameter longint unsigned IDLE_TICKS = ddr_init_pkg::IDLE_TICKS,
    parameter longint unsigned IDLE_DBG_TICKS = ddr_init_pkg::IDLE_DBG_TICKS
) (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // AXI4-Lite write channels.
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels.
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Link to the memory.
    ddr_link_if.ctrl         link
);
    import ddr_init_pkg::*;

    if (CK_DIV < 4 || CK_DIV > 16 || CK_DIV % 2 != 0 || POST_RESET_CYC < 1 || IDLE_TICKS < 2 ||
        IDLE_DBG_TICKS < 2 || IDLE_TICKS >= (64'd1 << IDLE_W) || IDLE_DBG_TICKS >= (64'd1 << IDLE_W)) begin : g_bad_param
        $error("ddr_ctrl_end: divider or wait parameters out of range");
    end

    state_t state;
    logic [3:0]  div_cnt;
    logic [31:0] wait_cnt;
    logic [2:0]  seq_idx;
    logic [IDLE_W-1:0] idle_cnt;
    logic [15:0] refi_cnt;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [1:0]  ctrl;
    logic [MR_W-1:0] mr_reg [MR_COUNT];
    logic        start_pend;
    logic        recal_pend;
    logic        issue_pend;
    logic        issue_long;
    logic [2:0]  issue_sel;

    // Link clock divider: commands change with the falling edge, the memory samples on the rising.
    wire        tick = (div_cnt == 4'(CK_DIV - 1));
    wire [3:0]  next_div = tick ? 4'h0 : div_cnt + 4'h1;
    wire        wait_zero = (wait_cnt == '0);
    wire        go = tick & wait_zero;

    // Bus decode.
    wire        do_write = ~awready & ~wready & ~bvalid;
    wire        do_read = arvalid & arready;
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire        wr_ctrl = do_write & (aw_addr == REG_CTRL);
    wire        wr_cmd = do_write & (aw_addr == REG_CMD);
    wire [7:0]  wr_mr_off = aw_addr - REG_MR_BASE;
    wire        wr_mr = do_write & (aw_addr >= REG_MR_BASE) & (wr_mr_off[7:2] < 6'(MR_COUNT)) & (aw_addr[1:0] == 2'h0);
    wire        wr_ok = wr_ctrl | wr_cmd | wr_mr;
    wire [31:0] cmd_bits = w_data & wmask;
    wire [7:0]  rd_mr_off = araddr - REG_MR_BASE;
    wire        rd_mr = (araddr >= REG_MR_BASE) & (rd_mr_off[7:2] < 6'(MR_COUNT)) & (araddr[1:0] == 2'h0);
    wire        rd_ok = rd_mr | (araddr == REG_CTRL) | (araddr == REG_CMD) | (araddr == REG_STATUS);
    wire [31:0] stat_word = {21'h0, state, (state == S_READY), (state != S_READY && state != S_IDLE)};
    wire [31:0] rd_word = rd_mr ? 32'(mr_reg[rd_mr_off[4:2]]) :
                          (araddr == REG_CTRL) ? 32'(ctrl) :
                          (araddr == REG_STATUS) ? stat_word : 32'h0;

    // Sequencer decisions taken at a link tick in the ready state; a start is also taken in the idle state.
    wire [2:0]  init_sel = MR_ORDER[seq_idx];
    wire        rdy_go = go & (state == S_READY) & link.cke;
    wire        take_start = go & (state == S_READY || state == S_IDLE) & start_pend;
    wire        take_recal = rdy_go & ~start_pend & recal_pend;
    wire        take_issue = rdy_go & ~start_pend & ~recal_pend & issue_pend;
    wire        rdy_free = rdy_go & ~start_pend & ~recal_pend & ~issue_pend;
    wire        take_ref = rdy_free & ctrl[CTRL_REF_EN] & (refi_cnt >= 16'(REFI_TICKS - 1));
    wire [IDLE_W-1:0] idle_lim = ctrl[CTRL_DEBUG] ? IDLE_W'(IDLE_DBG_TICKS - 1) : IDLE_W'(IDLE_TICKS - 1);
    wire        take_tog = rdy_free & ~take_ref & (idle_cnt >= idle_lim);

    // Write and read channels: address and data taken in either order, answer after both.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= '0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
            if (do_read) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // Software registers; a pending order is set by a write and the set wins over the take.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl <= '0;
            start_pend <= 1'b0;
            recal_pend <= 1'b0;
            issue_pend <= 1'b0;
            issue_long <= 1'b0;
            issue_sel <= '0;
            for (int i = 0; i < MR_COUNT; i++) begin
                mr_reg[i] <= '0;
            end
        end else begin
            if (wr_ctrl) begin
                ctrl <= (ctrl & wmask[1:0]) ^ (ctrl & wmask[1:0]) | (w_data[1:0] & wmask[1:0]) | (ctrl & ~wmask[1:0]);
            end
            if (wr_mr) begin
                mr_reg[wr_mr_off[4:2]] <= (mr_reg[wr_mr_off[4:2]] & ~wmask[MR_W-1:0]) | (w_data[MR_W-1:0] & wmask[MR_W-1:0]);
            end
            start_pend <= (start_pend & ~take_start) | (wr_cmd & cmd_bits[CMD_START]);
            recal_pend <= (recal_pend & ~take_recal & ~take_start) | (wr_cmd & cmd_bits[CMD_RECAL]);
            issue_pend <= (issue_pend & ~take_issue & ~take_start) | (wr_cmd & cmd_bits[CMD_ISSUE]);
            if (wr_cmd && cmd_bits[CMD_ISSUE]) begin
                issue_sel <= cmd_bits[CMD_SEL_LSB +: 3];
                issue_long <= cmd_bits[CMD_LONG];
            end
        end
    end

    // Divider, link clock, idle and refresh interval counters.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_cnt <= '0;
            link.ck <= 1'b0;
            idle_cnt <= '0;
            refi_cnt <= '0;
        end else begin
            div_cnt <= next_div;
            link.ck <= (next_div >= 4'(CK_HALF));
            if (tick) begin
                idle_cnt <= (take_tog || take_ref || state != S_READY) ? '0 : idle_cnt + IDLE_W'(1);
                refi_cnt <= (take_ref || state != S_READY) ? '0 : refi_cnt + 16'h0001;
            end
        end
    end

    // Sequencer: reset pulse, CKE, MRS chain, ZQCL, calibration wait, then runtime service.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= S_IDLE;
            wait_cnt <= '0;
            seq_idx <= '0;
            link.reset_n <= 1'b0;
            link.cke <= 1'b0;
            link.ten <= 1'b0;
            {link.cs_n, link.act_n, link.ras_n, link.cas_n, link.we_n} <= CMD_DES;
            link.bg <= '0;
            link.ba <= '0;
            link.addr <= '0;
        end else begin
            link.ten <= 1'b0;
            if (!wait_zero) begin
                wait_cnt <= wait_cnt - 32'h1;
            end
            if (tick) begin
                {link.cs_n, link.act_n, link.ras_n, link.cas_n, link.we_n} <= CMD_DES;
            end
            case (state)
                S_IDLE: begin
                    if (take_start) begin
                        state <= S_RST;
                    end
                end
                S_RST: begin
                    link.reset_n <= 1'b0;
                    link.cke <= 1'b0;
                    state <= S_POST;
                    wait_cnt <= 32'(PW_RESET_CYC + CKE_SETUP_CYC - 1);
                end
                S_POST: begin
                    if (wait_zero && !link.reset_n) begin
                        link.reset_n <= 1'b1;
                        wait_cnt <= 32'(POST_RESET_CYC - 1);
                    end else if (wait_zero && tick) begin
                        link.cke <= 1'b1;
                        state <= S_XPR;
                        wait_cnt <= 32'(XPR_CYC - 1);
                        seq_idx <= '0;
                    end
                end
                S_XPR: begin
                    if (wait_zero) begin
                        state <= S_MRS;
                    end
                end
                S_MRS: begin
                    if (go) begin
                        {link.cs_n, link.act_n, link.ras_n, link.cas_n, link.we_n} <= CMD_MRS;
                        {link.bg[0], link.ba} <= init_sel;
                        link.bg[1] <= 1'b0;
                        link.addr <= mr_reg[init_sel];
                        seq_idx <= seq_idx + 3'h1;
                        if (seq_idx == MR_LAST) begin
                            state <= S_ZQ;
                            wait_cnt <= 32'(T_MOD_NCK * CK_DIV - 1);
                        end else begin
                            wait_cnt <= 32'(T_MRD_NCK * CK_DIV - 1);
                        end
                    end
                end
                S_ZQ: begin
                    if (go) begin
                        {link.cs_n, link.act_n, link.ras_n, link.cas_n, link.we_n} <= CMD_ZQC;
                        link.addr <= 18'(1) << ZQ_LONG_BIT;
                        state <= S_CAL;
                        wait_cnt <= 32'(T_CAL_NCK * CK_DIV - 1);
                    end
                end
                S_CAL, S_GAP: begin
                    if (wait_zero) begin
                        state <= S_READY;
                    end
                end
                S_READY: begin
                    if (take_start) begin
                        state <= S_RST;
                    end else if (take_recal) begin
                        {link.cs_n, link.act_n, link.ras_n, link.cas_n, link.we_n} <= CMD_MRS;
                        {link.bg, link.ba} <= {1'b0, MR0_SEL};
                        link.addr <= mr_reg[MR0_SEL] | (18'(1) << DLL_RESET_BIT);
                        state <= S_ZQ;
                        wait_cnt <= 32'(T_MOD_NCK * CK_DIV - 1);
                    end else if (take_issue) begin
                        {link.cs_n, link.act_n, link.ras_n, link.cas_n, link.we_n} <= CMD_MRS;
                        {link.bg, link.ba} <= {1'b0, issue_sel};
                        link.addr <= mr_reg[issue_sel];
                        state <= S_GAP;
                        wait_cnt <= issue_long ? 32'(T_LONG_NCK * CK_DIV - 1) : 32'(T_MOD_NCK * CK_DIV - 1);
                    end else if (take_ref) begin
                        {link.cs_n, link.act_n, link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
                        state <= S_GAP;
                        wait_cnt <= 32'(T_RFC_NCK * CK_DIV - 1);
                    end else if (take_tog) begin
                        link.cke <= 1'b0;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
            if (tick && state == S_READY && !link.cke) begin
                link.cke <= 1'b1;
            end
        end
    end
endmodule

// ### ddr_dram_end.sv
// Memory end: samples the link, holds the mode registers and reports readiness.
`timescale 1ns/10ps
module ddr_dram_end (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Link from the controller.
    ddr_link_if.dram         link,
    // User side.
    input  wire logic [2:0]  mr_sel,
    output logic      [17:0] mr_data,
    output logic      [6:0]  mr_written,
    output logic             dll_locked,
    output logic             zq_done,
    output logic             dev_ready,
    output logic      [15:0] refresh_count
);
    localparam int PIN_W = 31;

    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [PIN_W-1:0] pin_s3;
    logic [PIN_W-1:0] pin_lvl;
    logic             ck_prev;
    logic [ddr_init_pkg::MR_W-1:0] mr [ddr_init_pkg::MR_COUNT];
    logic [10:0]      dll_cnt;
    logic [10:0]      zq_cnt;

    wire [PIN_W-1:0] pin_raw = {link.ck, link.reset_n, link.cke, link.cs_n, link.act_n, link.ras_n,
                                link.cas_n, link.we_n, link.ten, link.bg, link.ba, link.addr};
    wire [PIN_W-1:0] pin_diff = pin_s2 ^ pin_s3;
    wire             ck_lvl = pin_lvl[30];
    wire             rstn_lvl = pin_lvl[29];
    wire             cke_lvl = pin_lvl[28];
    wire [4:0]       cmd_lvl = pin_lvl[27:23];
    wire [2:0]       sel_lvl = {pin_lvl[20], pin_lvl[19:18]};
    wire [17:0]      addr_lvl = pin_lvl[17:0];
    wire             ck_rise = ck_lvl & ~ck_prev;
    wire             cmd_take = ck_rise & cke_lvl & ~cmd_lvl[4];
    wire             is_mrs = cmd_take & (cmd_lvl == ddr_init_pkg::CMD_MRS) & (sel_lvl < 3'(ddr_init_pkg::MR_COUNT));
    wire             is_ref = cmd_take & (cmd_lvl == ddr_init_pkg::CMD_REF);
    wire             is_zq = cmd_take & (cmd_lvl == ddr_init_pkg::CMD_ZQC) & addr_lvl[ddr_init_pkg::ZQ_LONG_BIT];
    wire             is_dll = is_mrs & (sel_lvl == ddr_init_pkg::MR0_SEL) & addr_lvl[ddr_init_pkg::DLL_RESET_BIT];

    // Three-stage pin sampling; a bit's level moves only when stages two and three agree.
    always_ff @(posedge clk_sys) begin
        pin_s1 <= pin_raw;
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
        pin_lvl <= (pin_s3 & ~pin_diff) | (pin_lvl & pin_diff);
        ck_prev <= ck_lvl;
    end

    // Mode register store; new values apply whenever an MRS arrives, ready or not.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < ddr_init_pkg::MR_COUNT; i++) begin
                mr[i] <= '0;
            end
        end else if (is_mrs) begin
            mr[sel_lvl] <= addr_lvl;
        end
    end

    // Written flags, calibration timers and the refresh tally.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mr_written <= '0;
            dll_cnt <= '0;
            zq_cnt <= '0;
            dll_locked <= 1'b0;
            zq_done <= 1'b0;
            dev_ready <= 1'b0;
            refresh_count <= '0;
        end else if (!rstn_lvl) begin
            mr_written <= '0;
            dll_cnt <= '0;
            zq_cnt <= '0;
            dll_locked <= 1'b0;
            zq_done <= 1'b0;
            dev_ready <= 1'b0;
        end else begin
            if (is_mrs) begin
                mr_written[sel_lvl] <= 1'b1;
            end
            if (is_dll) begin
                dll_cnt <= 11'(ddr_init_pkg::T_DLLK_NCK);
                dll_locked <= 1'b0;
            end else if (ck_rise && dll_cnt != '0) begin
                dll_cnt <= dll_cnt - 11'h001;
                dll_locked <= (dll_cnt == 11'h001);
            end
            if (is_zq) begin
                zq_cnt <= 11'(ddr_init_pkg::T_ZQINIT_NCK);
                zq_done <= 1'b0;
            end else if (ck_rise && zq_cnt != '0) begin
                zq_cnt <= zq_cnt - 11'h001;
                zq_done <= (zq_cnt == 11'h001);
            end
            if (is_ref) begin
                refresh_count <= refresh_count + 16'h0001;
            end
            dev_ready <= (&mr_written) & dll_locked & zq_done;
        end
    end

    // Mode register readback; the array itself is cleared only by rst, never by reset_n low.
    always_ff @(posedge clk_sys) begin
        mr_data <= (mr_sel < 3'(ddr_init_pkg::MR_COUNT)) ? mr[mr_sel] : '0;
    end
endmodule

// ### ddr_init_and_mode_register_sequencing_test.sv
// Self-checking bench joining the controller end and the memory end.
`timescale 1ns/10ps
module ddr_init_and_mode_register_sequencing_test;
    logic        clk_sys = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, dll_locked, zq_done, dev_ready;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp;
    logic [2:0]  mr_sel = 0;
    logic [17:0] mr_data, mv [7];
    logic [6:0]  mr_written;
    logic [15:0] refresh_count, rc;
    logic [33:0] exp_q [$];
    int          failures = 0, n_tests = 0, seed = 44, i, n_tog = 0, tog0;
    ddr_link_if lnk ();
    ddr_ctrl_end #(.POST_RESET_CYC(40), .IDLE_TICKS(50), .IDLE_DBG_TICKS(100)) u_ddr_ctrl_end (.*, .link(lnk));
    ddr_dram_end u_ddr_dram_end (.*, .link(lnk));
    ddr_init_props u_ddr_init_props (.clk_sys(clk_sys), .rst(rst), .reset_n(lnk.reset_n), .cke(lnk.cke),
        .cs_n(lnk.cs_n), .act_n(lnk.act_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n),
        .ten(lnk.ten), .bg(lnk.bg), .ba(lnk.ba), .addr(lnk.addr));
    always #25 clk_sys = ~clk_sys;
    // Takes the oldest note off the queue and compares it.
    task automatic see(input logic [33:0] g);
        logic [33:0] e;
        e = exp_q.pop_front();
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk(input logic [33:0] g, e);
        exp_q.push_back(e);
        see(g);
    endtask
    // Write one word; each channel is released at its own handshake.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 0;
        end while (!rvalid);
    endtask
    // Watches both response channels and compares against the notes.
    always @(posedge clk_sys) begin
        if (bvalid && bready) see({bresp, 32'h0});
        if (rvalid && rready) see({rresp, rdata});
    end
    // Counts every CKE fall seen on the link, idle toggles and reset entries alike.
    always @(negedge lnk.cke) n_tog++;
    task automatic give_verdict();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Cuts a hung run short.
    initial begin
        #3000000;
        failures++;
        give_verdict();
    end
    // Main sequence: load, start, verify, runtime update, refresh, second reset.
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 0;
        for (i = 0; i < 7; i++) begin
            mv[i] = 18'($random(seed)) | (i == 0 ? 18'h100 : 18'h0);
            wr(8'(8'h10 + 4 * i), 32'(mv[i]), 2'h0);
            rd(8'(8'h10 + 4 * i), {16'h0, mv[i]});
        end
        wr(8'hFC, 32'h0, 2'h2);
        rd(8'hFC, {2'h2, 32'h0});
        wr(8'h04, 32'h1, 2'h0);
        for (i = 0; i < 12000 && dev_ready !== 1'b1; i++) @(posedge clk_sys);
        chk({27'h0, mr_written}, 34'h7F);
        rd(8'h08, 34'h202);
        for (i = 0; i < 7; i++) begin
            mr_sel <= 3'(i);
            repeat (3) @(posedge clk_sys);
            chk({16'h0, mr_data}, {16'h0, mv[i]});
        end
        mv[2] = 18'($random(seed));
        wr(8'h18, 32'(mv[2]), 2'h0);
        wr(8'h04, 32'h2C, 2'h0);
        mr_sel <= 3'h2;
        repeat (600) @(posedge clk_sys);
        chk({16'h0, mr_data}, {16'h0, mv[2]});
        wr(8'h00, 32'h1, 2'h0);
        repeat (500) @(posedge clk_sys);
        chk({33'h0, refresh_count != 16'h0}, 34'h1);
        wr(8'h00, 32'h2, 2'h0);
        @(negedge lnk.cke);
        @(posedge clk_sys);
        tog0 = n_tog;
        repeat (600) @(posedge clk_sys);
        chk(34'(n_tog - tog0), 34'h0);
        repeat (400) @(posedge clk_sys);
        chk(34'(n_tog - tog0), 34'h1);
        wr(8'h04, 32'h2, 2'h0);
        repeat (100) @(posedge clk_sys);
        chk({31'h0, dll_locked, zq_done, dev_ready}, 34'h2);
        for (i = 0; i < 12000 && dev_ready !== 1'b1; i++) @(posedge clk_sys);
        chk({31'h0, dll_locked, zq_done, dev_ready}, 34'h7);
        rc = refresh_count;
        wr(8'h04, 32'h1, 2'h0);
        repeat (20) @(posedge clk_sys);
        chk({18'h0, refresh_count}, {18'h0, rc});
        chk({27'h0, mr_written}, 34'h0);
        give_verdict();
    end
endmodule

// ### ddr_init_pkg.sv
// Shared constants, register map, link command codes and state type for the DDR4 init ends.
package ddr_init_pkg;
    // System clock and the link clock divider (link period = CLK_NS * CK_DIV).
    localparam int CLK_NS = 50;
    localparam int CK_DIV = 8;
    localparam int CK_HALF = CK_DIV / 2;
    localparam int CK_NS = CLK_NS * CK_DIV;

    // Reset pulse, CKE setup and post-release wait; least times round up.
    localparam int T_PW_RESET_NS = 1000;
    localparam int PW_RESET_CYC = (T_PW_RESET_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_CKE_SETUP_NS = 10;
    localparam int CKE_SETUP_CYC = (T_CKE_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_POST_RESET_US = 500;
    localparam int POST_RESET_CYC = (T_POST_RESET_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int T_XPR_NS = 1000;
    localparam int XPR_CYC = (T_XPR_NS + CLK_NS - 1) / CLK_NS;

    // Command spacing in link clock cycles.
    localparam int T_MRD_NCK = 8;
    localparam int T_MOD_NCK = 24;
    localparam int T_LONG_NCK = 64;
    localparam int T_RFC_NCK = 16;
    localparam int T_DLLK_NCK = 1024;
    localparam int T_ZQINIT_NCK = 1024;
    localparam int T_CAL_NCK = (T_DLLK_NCK > T_ZQINIT_NCK) ? T_DLLK_NCK : T_ZQINIT_NCK;

    // Refresh interval and idle limits; longest times round down.
    localparam int T_REFI_NS = 7800;
    localparam int REFI_TICKS = T_REFI_NS / CK_NS;
    localparam longint unsigned T_IDLE_MS = 960;
    localparam longint unsigned T_IDLE_DBG_MIN = 60;
    localparam longint unsigned IDLE_TICKS = T_IDLE_MS * 64'd1000000 / CK_NS;
    localparam longint unsigned IDLE_DBG_TICKS = T_IDLE_DBG_MIN * 64'd60000000000 / CK_NS;
    localparam int IDLE_W = 34;

    // Mode registers and their initialization order.
    localparam int MR_COUNT = 7;
    localparam int MR_W = 18;
    localparam logic [2:0] MR_ORDER [MR_COUNT] = '{3'h3, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
    localparam logic [2:0] MR_LAST = 3'h6;
    localparam logic [2:0] MR0_SEL = 3'h0;
    localparam int DLL_RESET_BIT = 8;
    localparam int ZQ_LONG_BIT = 10;

    // Link command codes as {cs_n, act_n, ras_n, cas_n, we_n}.
    localparam logic [4:0] CMD_DES = 5'h1F;
    localparam logic [4:0] CMD_MRS = 5'h08;
    localparam logic [4:0] CMD_REF = 5'h09;
    localparam logic [4:0] CMD_ZQC = 5'h0E;

    // Register map of the controller.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MR_BASE = 8'h10;
    localparam int CTRL_REF_EN = 0;
    localparam int CTRL_DEBUG = 1;
    localparam int CMD_START = 0;
    localparam int CMD_RECAL = 1;
    localparam int CMD_ISSUE = 2;
    localparam int CMD_LONG = 3;
    localparam int CMD_SEL_LSB = 4;
    localparam int STAT_READY = 1;
    localparam int STAT_STATE_LSB = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [8:0] {
        S_IDLE  = 9'h001,
        S_RST   = 9'h002,
        S_POST  = 9'h004,
        S_XPR   = 9'h008,
        S_MRS   = 9'h010,
        S_ZQ    = 9'h020,
        S_CAL   = 9'h040,
        S_READY = 9'h080,
        S_GAP   = 9'h100
    } state_t;
endpackage

// ### ddr_init_props.sv
// Link timing checks between the controller end and the memory end.
`timescale 1ns/10ps
module ddr_init_props (
    // Clock and reset.
    input wire logic        clk_sys,
    input wire logic        rst,
    // Link signals.
    input wire logic        reset_n,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        act_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic        ten,
    input wire logic [1:0]  bg,
    input wire logic [1:0]  ba,
    input wire logic [17:0] addr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Command decode and the first cycle of each command.
    logic [4:0]  cmd_q;
    logic [15:0] g_mrs, g_zq;
    wire  [4:0]  cmd    = {cs_n, act_n, ras_n, cas_n, we_n};
    wire         mrs_go = cmd == ddr_init_pkg::CMD_MRS && cmd_q != cmd;
    wire         zq_go  = cmd == ddr_init_pkg::CMD_ZQC && cmd_q != cmd;
    wire         ref_go = cmd == ddr_init_pkg::CMD_REF && cmd_q != cmd;
    // Saturating cycle counts since the last MRS and the last ZQCL start.
    always_ff @(posedge clk_sys) begin
        cmd_q <= cmd;
        g_mrs <= rst ? 16'hFFFF : mrs_go ? 16'h0001 : g_mrs + {15'h0, ~&g_mrs};
        g_zq  <= rst ? 16'hFFFF : zq_go ? 16'h0001 : g_zq + {15'h0, ~&g_zq};
    end
    a_ten_low: assert property (!ten) else $error("ten high");
    a_mrs_select: assert property (mrs_go |-> !bg[1] && {bg[0], ba} != 3'h7) else $error("bad select");
    a_cke_reset: assert property (!reset_n |-> !cke) else $error("cke high in reset");
    a_reset_width: assert property ($fell(reset_n) |=> !reset_n [*8]) else $error("short reset");
    a_mrd_gap: assert property (mrs_go |-> g_mrs >= 16'd64) else $error("MRS too close");
    a_mod_gap: assert property (zq_go || ref_go |-> g_mrs >= 16'd192) else $error("tMOD short");
    a_cal_wait: assert property (ref_go |-> g_zq >= 16'd8192) else $error("REF too early");
    a_cmd_frame: assert property ($fell(cs_n) |=> $stable({cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr}) [*7]
        ##1 cs_n) else $error("bad frame");
    c_mrs: cover property (mrs_go);
    c_zq: cover property (zq_go);
    c_ref: cover property (ref_go);
endmodule

// ### ddr_link_if.sv
// Link between the controller end and the memory end.
`timescale 1ns/10ps
interface ddr_link_if;
    logic        ck;
    logic        reset_n;
    logic        cke;
    logic        cs_n;
    logic        act_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        ten;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [17:0] addr;

    modport ctrl (output ck, reset_n, cke, cs_n, act_n, ras_n, cas_n, we_n, ten, bg, ba, addr);
    modport dram (input ck, reset_n, cke, cs_n, act_n, ras_n, cas_n, we_n, ten, bg, ba, addr);
endinterface
